// ---- core/rsp_pkg.sv ----
/*
  Constants and helper functions for the
  serial host port of a real-time clock, both link ends.
  Assumes one system clock CLK at 125 MHz shared by both ends.
*/
package rsp_pkg;

    // =========================================================
    // Variants
    localparam int VAR_MODE13 = 0;
    localparam int VAR_MODE02 = 1;
    localparam int VAR_3WIRE  = 2;

    // =========================================================
    // Layout and counts
    localparam int          BYTE_W      = 8;
    localparam int          DIR_BIT     = 7;
    localparam int          FIFO_DEPTH  = 8;
    localparam int          CMD_W       = BYTE_W + 1;
    localparam logic [7:0]  PTR_RESET   = 8'h00;
    localparam int          CLK_MHZ     = 125;
    localparam int          SCLK_HALF_NS = 64;
    localparam int          SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int          MIN_HALF_CYC = 8;

    // =========================================================
    // Helpers
    function automatic logic [7:0] inc_ptr(input logic [7:0] p);
        return {p[DIR_BIT], 3'h0, p[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] b, input logic d, input logic lsb);
        return lsb ? {d, b[7:1]} : {b[6:0], d};
    endfunction

    function automatic logic first_bit(input logic [7:0] b, input logic lsb);
        return lsb ? b[0] : b[7];
    endfunction

    function automatic logic [7:0] advance(input logic [7:0] b, input logic lsb);
        return lsb ? {1'h0, b[7:1]} : {b[6:0], 1'h0};
    endfunction

endpackage

// ---- core/rsp_if.sv ----
/*
  Link between the serial master and the clock's host port.
  Assumes a pull-up on the shared three-wire line; the device end
  wins any overlap at a direction change.
*/
`timescale 1ns/1ps
`default_nettype none
interface rsp_if;
    logic sclk;
    logic cs_n;
    logic ce;
    logic mosi;
    logic host_oe;
    logic miso;
    logic miso_oe;
    logic io;
    logic sdo_line;

    assign io       = miso_oe ? miso : (host_oe ? mosi : 1'h1);
    assign sdo_line = miso_oe ? miso : 1'h1;

    modport dev (input sclk, cs_n, ce, mosi, io, output miso, miso_oe);
    modport host (output sclk, cs_n, ce, mosi, host_oe, input sdo_line, io);
endinterface
`default_nettype wire

// ---- core/rsp_fifo.sv ----
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes a single clock; EN low freezes all state.
*/
`timescale 1ns/1ps
`default_nettype none
module rsp_fifo
    import rsp_pkg::*;
#(
    parameter int W = CMD_W,
    parameter int D = FIFO_DEPTH
)(
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         en,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    if (D < 2 || (1 << AW) != D) begin : g_chk
        $error("FIFO depth must be a power of two, at least 2");
    end

    logic [W-1:0] mem_reg [D];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0]   cnt_reg;
    logic          push;
    logic          pop;

    assign in_ready  = cnt_reg != (AW+1)'(D);
    assign out_valid = cnt_reg != '0;
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (en && push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else if (en) begin
            if (push) wr_reg <= wr_reg + 1'h1;
            if (pop) rd_reg <= rd_reg + 1'h1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ---- core/rsp_dev.sv ----
/*
  Clock-side end of the serial host port: address decode, direction,
  burst pointer with wrap, read shifter, write strobes, time snapshot.
  Assumes link pins are asynchronous to CLK and that the master's
  half bit period spans at least eight CLK cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module rsp_dev
    import rsp_pkg::*;
#(
    parameter int VARIANT = VAR_MODE13
)(
    input  wire logic       CLK,
    input  wire logic       NRST,
    input  wire logic       CLK_EN,
    rsp_if.dev              LINK,
    output logic [7:0]      REG_ADDR,
    output logic [7:0]      REG_WDATA,
    output logic            REG_WE,
    output logic            REG_RE,
    input  wire logic [7:0] REG_RDATA,
    output logic            SNAP,
    output logic            BUSY
);
    if (VARIANT < VAR_MODE13 || VARIANT > VAR_3WIRE) begin : g_chk
        $error("Unknown link variant");
    end

    typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA} rsp_phase_t;

    localparam logic LSB   = (VARIANT == VAR_3WIRE);
    localparam logic CPHA1 = (VARIANT == VAR_MODE13);

    // =========================================================
    // Pin synchronisers
    logic sclk_m;
    logic sclk_s;
    logic sclk_d;
    logic sel_m;
    logic sel_s;
    logic sel_d;
    logic dat_m;
    logic dat_s;
    logic sel_raw;
    logic dat_raw;

    // Three-wire enable is active high, four-wire select active low
    assign sel_raw = LSB ? LINK.ce : ~LINK.cs_n;
    assign dat_raw = LSB ? LINK.io : LINK.mosi;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            sclk_m <= 1'h0;
            sclk_s <= 1'h0;
            sclk_d <= 1'h0;
            sel_m  <= 1'h0;
            sel_s  <= 1'h0;
            sel_d  <= 1'h0;
            dat_m  <= 1'h0;
            dat_s  <= 1'h0;
        end else if (CLK_EN) begin
            sclk_m <= LINK.sclk;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            sel_m  <= sel_raw;
            sel_s  <= sel_m;
            sel_d  <= sel_s;
            dat_m  <= dat_raw;
            dat_s  <= dat_m;
        end
    end

    // =========================================================
    // Edge decode
    logic cpol_reg;
    logic samp_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic in_frame;
    logic sel_start;
    logic strobe;
    logic shift;

    assign sel_start = sel_s & ~sel_d;
    assign in_frame  = sel_s & sel_d;
    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;

    // Idle clock level at select tells the polarity of the mode
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            cpol_reg <= 1'h0;
        end else if (CLK_EN && sel_start) begin
            cpol_reg <= sclk_s;
        end
    end

    assign samp_rise = LSB ? 1'h1 : ~(CPHA1 ^ cpol_reg);
    assign strobe    = in_frame & (samp_rise ? sclk_rise : sclk_fall);
    assign shift     = in_frame & (samp_rise ? sclk_fall : sclk_rise);

    // =========================================================
    // Framing and bit count
    rsp_phase_t  phase_reg;
    logic [2:0]  bit_cnt_reg;
    logic [7:0]  rx_reg;
    logic [7:0]  rx_byte;
    logic        byte_done;

    assign rx_byte   = shift_in(rx_reg, dat_s, LSB);
    assign byte_done = strobe & (bit_cnt_reg == 3'h7);

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            phase_reg <= PH_IDLE;
        end else if (CLK_EN) begin
            if (!sel_s) begin
                phase_reg <= PH_IDLE;
            end else begin
                unique case (phase_reg)
                    PH_IDLE: phase_reg <= PH_ADDR;
                    PH_ADDR: if (byte_done) phase_reg <= PH_DATA;
                    PH_DATA: phase_reg <= PH_DATA;
                endcase
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            bit_cnt_reg <= 3'h0;
            rx_reg      <= 8'h00;
        end else if (CLK_EN) begin
            if (!sel_s) begin
                bit_cnt_reg <= 3'h0;
            end else if (strobe) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                rx_reg      <= rx_byte;
            end
        end
    end

    // =========================================================
    // Direction, pointer and write strobe
    logic       wr_reg;
    logic [7:0] ptr_reg;
    logic       we_reg;
    logic [7:0] wdata_reg;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            wr_reg  <= 1'h0;
            ptr_reg <= PTR_RESET;
        end else if (CLK_EN) begin
            if (byte_done && phase_reg == PH_ADDR) begin
                wr_reg  <= rx_byte[DIR_BIT];
                ptr_reg <= rx_byte;
            end else if (byte_done && !wr_reg) begin
                ptr_reg <= inc_ptr(ptr_reg);
            end else if (we_reg) begin
                // Held one cycle so the strobe sees the written address
                ptr_reg <= inc_ptr(ptr_reg);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            we_reg    <= 1'h0;
            wdata_reg <= 8'h00;
        end else if (CLK_EN) begin
            we_reg <= byte_done & (phase_reg == PH_DATA) & wr_reg;
            if (byte_done) begin
                wdata_reg <= rx_byte;
            end
        end
    end

    // =========================================================
    // Read shifter
    logic       rd_shift;
    logic       rd_load;
    logic [7:0] tx_src;
    logic [7:0] tx_reg;
    logic       out_reg;
    logic       oe_reg;
    logic       re_reg;

    assign rd_shift = shift & (phase_reg == PH_DATA) & ~wr_reg;
    assign rd_load  = rd_shift & (bit_cnt_reg == 3'h0);
    assign tx_src   = rd_load ? REG_RDATA : tx_reg;

    // A trailing shift after the last byte prefetches one extra register
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            tx_reg  <= 8'h00;
            out_reg <= 1'h0;
            re_reg  <= 1'h0;
        end else if (CLK_EN) begin
            re_reg <= rd_load;
            if (rd_shift) begin
                out_reg <= first_bit(tx_src, LSB);
                tx_reg  <= advance(tx_src, LSB);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            oe_reg <= 1'h0;
        end else if (CLK_EN) begin
            if (!sel_s) begin
                oe_reg <= 1'h0;
            end else if (rd_load) begin
                oe_reg <= 1'h1;
            end
        end
    end

    // =========================================================
    // Time snapshot
    logic snap_reg;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            snap_reg <= 1'h0;
        end else if (CLK_EN) begin
            snap_reg <= sel_start;
        end
    end

    assign LINK.miso    = out_reg;
    assign LINK.miso_oe = oe_reg;
    assign REG_ADDR     = ptr_reg;
    assign REG_WDATA    = wdata_reg;
    assign REG_WE       = we_reg;
    assign REG_RE       = re_reg;
    assign SNAP         = snap_reg;
    assign BUSY         = sel_d;
endmodule
`default_nettype wire

// ---- core/rsp_host.sv ----
/*
  Master end of the serial host port: makes the bit clock by a
  divider, frames transactions from a byte FIFO, returns read bytes.
  Assumes the clock-side end answers within a few CLK cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module rsp_host
    import rsp_pkg::*;
#(
    parameter int   VARIANT  = VAR_MODE13,
    parameter logic CPOL     = 1'h0,
    parameter int   HALF_CYC = SCLK_HALF_CYC,
    parameter int   DEPTH    = FIFO_DEPTH
)(
    input  wire logic       CLK,
    input  wire logic       NRST,
    input  wire logic       CLK_EN,
    input  wire logic       CMD_VALID,
    output logic            CMD_READY,
    input  wire logic [7:0] CMD_DATA,
    input  wire logic       CMD_LAST,
    output logic [7:0]      RD_DATA,
    output logic            RD_VALID,
    output logic            BUSY,
    rsp_if.host             LINK
);
    if (VARIANT < VAR_MODE13 || VARIANT > VAR_3WIRE || HALF_CYC < MIN_HALF_CYC || HALF_CYC > 255) begin : g_chk
        $error("Link variant or half bit period out of range");
    end

    typedef enum logic [2:0] {H_IDLE, H_A, H_B, H_NEXT, H_TAIL, H_GAP} rsp_hstate_t;

    localparam logic LSB   = (VARIANT == VAR_3WIRE);
    localparam logic CPHA1 = (VARIANT == VAR_MODE13);
    localparam logic IDLE_LVL = LSB ? 1'h0 : CPOL;

    // =========================================================
    // Command FIFO; stalls the bit engine when empty
    logic            f_valid;
    logic            f_ready;
    logic [CMD_W-1:0] f_data;

    rsp_fifo #(.W(CMD_W), .D(DEPTH)) u_fifo (
        .clk       (CLK),
        .nrst      (NRST),
        .en        (CLK_EN),
        .in_valid  (CMD_VALID),
        .in_ready  (CMD_READY),
        .in_data   ({CMD_LAST, CMD_DATA}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    // =========================================================
    // Input synchroniser
    logic din_m;
    logic din_s;

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            din_m <= 1'h1;
            din_s <= 1'h1;
        end else if (CLK_EN) begin
            din_m <= LSB ? LINK.io : LINK.sdo_line;
            din_s <= din_m;
        end
    end

    // =========================================================
    // Bit engine
    rsp_hstate_t st_reg;
    logic [7:0]  hcnt_reg;
    logic [2:0]  bit_reg;
    logic [7:0]  tx_reg;
    logic [7:0]  rx_reg;
    logic [7:0]  rx_new;
    logic        last_reg;
    logic        first_reg;
    logic        rd_reg;
    logic        sclk_reg;
    logic        sel_reg;
    logic        mosi_reg;
    logic        oe_reg;
    logic        rdv_reg;
    logic [7:0]  rdd_reg;
    logic        half_end;

    assign half_end = hcnt_reg == 8'(HALF_CYC - 1);
    assign rx_new   = shift_in(rx_reg, din_s, LSB);
    assign f_ready  = CLK_EN & ((st_reg == H_IDLE) | (st_reg == H_NEXT));

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            hcnt_reg <= 8'h00;
        end else if (CLK_EN) begin
            hcnt_reg <= (half_end || st_reg == H_IDLE || st_reg == H_NEXT) ? 8'h00 : hcnt_reg + 8'h01;
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            st_reg    <= H_IDLE;
            bit_reg   <= 3'h0;
            tx_reg    <= 8'h00;
            rx_reg    <= 8'h00;
            last_reg  <= 1'h0;
            first_reg <= 1'h0;
            rd_reg    <= 1'h0;
            sclk_reg  <= IDLE_LVL;
            sel_reg   <= 1'h0;
            mosi_reg  <= 1'h0;
            oe_reg    <= 1'h0;
            rdv_reg   <= 1'h0;
            rdd_reg   <= 8'h00;
        end else if (CLK_EN) begin
            rdv_reg <= 1'h0;
            unique case (st_reg)
                H_IDLE, H_NEXT: if (f_valid) begin
                    // Address byte first; its top bit fixes direction
                    last_reg  <= f_data[BYTE_W];
                    first_reg <= st_reg == H_IDLE;
                    if (st_reg == H_IDLE) rd_reg <= ~f_data[DIR_BIT];
                    oe_reg    <= (st_reg == H_IDLE) | ~rd_reg;
                    sel_reg   <= 1'h1;
                    bit_reg   <= 3'h0;
                    tx_reg    <= CPHA1 ? f_data[7:0] : advance(f_data[7:0], LSB);
                    if (!CPHA1) mosi_reg <= first_bit(f_data[7:0], LSB);
                    st_reg    <= H_A;
                end
                H_A: if (half_end) begin
                    sclk_reg <= ~IDLE_LVL;
                    if (CPHA1) begin
                        mosi_reg <= first_bit(tx_reg, LSB);
                        tx_reg   <= advance(tx_reg, LSB);
                    end else begin
                        rx_reg <= rx_new;
                    end
                    st_reg <= H_B;
                end
                H_B: if (half_end) begin
                    sclk_reg <= IDLE_LVL;
                    if (CPHA1) rx_reg <= rx_new;
                    if (bit_reg == 3'h7) begin
                        if (!first_reg && rd_reg) begin
                            rdv_reg <= 1'h1;
                            rdd_reg <= CPHA1 ? rx_new : rx_reg;
                        end
                        st_reg <= last_reg ? H_TAIL : H_NEXT;
                    end else begin
                        bit_reg <= bit_reg + 3'h1;
                        if (!CPHA1) begin
                            mosi_reg <= first_bit(tx_reg, LSB);
                            tx_reg   <= advance(tx_reg, LSB);
                        end
                        st_reg <= H_A;
                    end
                end
                H_TAIL: if (half_end) begin
                    sel_reg <= 1'h0;
                    oe_reg  <= 1'h0;
                    st_reg  <= H_GAP;
                end
                H_GAP: if (half_end) st_reg <= H_IDLE;
            endcase
        end
    end

    assign LINK.sclk    = sclk_reg;
    assign LINK.cs_n    = ~sel_reg;
    assign LINK.ce      = sel_reg;
    assign LINK.mosi    = mosi_reg;
    assign LINK.host_oe = LSB ? oe_reg : 1'h1;
    assign RD_DATA      = rdd_reg;
    assign RD_VALID     = rdv_reg;
    assign BUSY         = st_reg != H_IDLE;
endmodule
`default_nettype wire

// ---- tb/rsp_properties.sv ----
/*
  Concurrent checks on the four-wire link joining both ends.
  Assumes mode 3 (CPOL 1, variant of modes 1/3) and an eight-cycle half bit.
*/
`timescale 1ns/1ps
`default_nettype none
module rsp_properties (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic ce,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    // ==========================================
    // Helper counters
    logic       sclk_reg;
    logic [4:0] fall_cnt_reg;
    logic [3:0] since_fall_reg;
    always_ff @(posedge CLK) begin
        sclk_reg <= sclk;
    end
    // Counts raw falls in select; saturates so long bursts never wrap to zero
    always_ff @(posedge CLK) begin
        if (!NRST || cs_n) begin
            fall_cnt_reg <= 5'h00;
        end else if (sclk_reg && !sclk && fall_cnt_reg != 5'h1F) begin
            fall_cnt_reg <= fall_cnt_reg + 5'h01;
        end
    end
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            since_fall_reg <= 4'hF;
        end else if (sclk_reg && !sclk) begin
            since_fall_reg <= 4'h0;
        end else if (since_fall_reg != 4'hF) begin
            since_fall_reg <= since_fall_reg + 4'h1;
        end
    end
    // ==========================================
    // Properties
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    a_oe_off_idle: assert property (cs_n [*8] |-> !miso_oe)
        else $error("output enabled while deselected");
    a_oe_drop_deselect: assert property ($rose(cs_n) |-> ##[0:6] !miso_oe)
        else $error("output enable held after deselect");
    a_sclk_idle_level: assert property (cs_n [*2] |-> sclk)
        else $error("bit clock off idle level outside select");
    a_select_quiet_start: assert property ($fell(cs_n) |-> sclk [*6])
        else $error("bit clock moved too soon after select");
    a_oe_after_address: assert property ($rose(miso_oe) |-> fall_cnt_reg >= 5'h09)
        else $error("output enabled before address byte done");
    a_miso_shift_edge: assert property (miso_oe && $past(miso_oe) && !cs_n && $changed(miso)
        |-> since_fall_reg <= 4'h6)
        else $error("output bit changed away from shift edge");
    a_mosi_strobe_stable: assert property ($rose(sclk) && !cs_n |-> $stable(mosi))
        else $error("input bit changed at strobe edge");
    a_enable_mirror: assert property (ce == !cs_n)
        else $error("enable and select disagree");
    c_select: cover property ($fell(cs_n));
    c_read_out: cover property ($rose(miso_oe));
    c_deselect: cover property ($rose(cs_n));
endmodule
`default_nettype wire

// ---- tb/test_rtc_serial_host_port.sv ----
/*
  Testbench: host and clock ends joined in mode 3, and a three-wire pair fed the same commands.
  Assumes a 16-entry register model answering REG_RDATA combinationally.
*/
`timescale 1ns/1ps
`default_nettype none
module test_rtc_serial_host_port;
    import rsp_pkg::*;
    // ==========================================
    // Signals
    logic        clk;
    logic        nrst;
    logic        cmd_valid;
    logic        cmd_ready;
    logic [7:0]  cmd_data;
    logic        cmd_last;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        h_busy;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_we;
    logic        reg_re;
    logic [7:0]  reg_rdata;
    logic        snap;
    logic        d_busy;
    logic        cmd_ready3;
    logic [7:0]  rd_data3;
    logic        rd_valid3;
    logic        h_busy3;
    logic [7:0]  reg_addr3;
    logic [7:0]  reg_wdata3;
    logic        reg_we3;
    logic [7:0]  reg_rdata3;
    logic        snap3;
    logic [7:0]  mem3 [16];
    logic [7:0]  io_q [$];
    logic [7:0]  rd3_q [$];
    logic [7:0]  io_sh;
    int          nbits3;
    int          snap3_cnt;
    int          re_cnt;
    logic [7:0]  mem [16];
    logic [7:0]  wa_q [$];
    logic [7:0]  wd_q [$];
    logic [7:0]  rd_q [$];
    logic [7:0]  mo_q [$];
    logic [7:0]  so_q [$];
    logic [7:0]  mo_sh;
    logic [7:0]  so_sh;
    int          nbits;
    int          snap_cnt;
    int          cycles;
    int          n_errors;
    int          tests_run;
    rsp_if lk();
    rsp_if lk3();
    // ==========================================
    // Design and checker
    rsp_host #(.VARIANT(VAR_MODE13), .CPOL(1'h1)) u_rsp_host (
        .CLK(clk), .NRST(nrst), .CLK_EN(1'h1), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
        .CMD_DATA(cmd_data), .CMD_LAST(cmd_last), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .BUSY(h_busy), .LINK(lk.host));
    rsp_dev #(.VARIANT(VAR_MODE13)) u_rsp_dev (
        .CLK(clk), .NRST(nrst), .CLK_EN(1'h1), .LINK(lk.dev), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RE(reg_re), .REG_RDATA(reg_rdata),
        .SNAP(snap), .BUSY(d_busy));
    rsp_host #(.VARIANT(VAR_3WIRE)) u_rsp_host_3w (
        .CLK(clk), .NRST(nrst), .CLK_EN(1'h1), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready3),
        .CMD_DATA(cmd_data), .CMD_LAST(cmd_last), .RD_DATA(rd_data3), .RD_VALID(rd_valid3),
        .BUSY(h_busy3), .LINK(lk3.host));
    rsp_dev #(.VARIANT(VAR_3WIRE)) u_rsp_dev_3w (
        .CLK(clk), .NRST(nrst), .CLK_EN(1'h1), .LINK(lk3.dev), .REG_ADDR(reg_addr3),
        .REG_WDATA(reg_wdata3), .REG_WE(reg_we3), .REG_RE(), .REG_RDATA(reg_rdata3),
        .SNAP(snap3), .BUSY());
    rsp_properties u_rsp_properties (
        .CLK(clk), .NRST(nrst), .sclk(lk.sclk), .cs_n(lk.cs_n), .ce(lk.ce),
        .mosi(lk.mosi), .miso(lk.miso), .miso_oe(lk.miso_oe));
    // ==========================================
    // Register model and monitors
    assign reg_rdata = mem[reg_addr[3:0]];
    assign reg_rdata3 = mem3[reg_addr3[3:0]];
    always @(posedge clk) begin
        if (reg_we === 1'h1) begin
            mem[reg_addr[3:0]] <= reg_wdata;
            wa_q.push_back(reg_addr);
            wd_q.push_back(reg_wdata);
        end
        if (rd_valid === 1'h1) rd_q.push_back(rd_data);
        if (snap === 1'h1) snap_cnt++;
        if (reg_we3 === 1'h1) mem3[reg_addr3[3:0]] <= reg_wdata3;
        if (reg_re === 1'h1) re_cnt++;
        if (rd_valid3 === 1'h1) rd3_q.push_back(rd_data3);
        if (snap3 === 1'h1) snap3_cnt++;
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // Wire view at the strobe edge, as the far side would latch it
    always @(posedge lk.sclk) begin
        if (lk.cs_n === 1'h0) begin
            mo_sh = {mo_sh[6:0], lk.mosi};
            so_sh = {so_sh[6:0], lk.sdo_line};
            nbits++;
            if (nbits % 8 == 0) begin
                mo_q.push_back(mo_sh);
                so_q.push_back(so_sh);
            end
        end
    end
    // Three-wire line at the strobe edge, LSB first
    always @(posedge lk3.sclk) begin
        if (lk3.ce === 1'h1) begin
            io_sh = {lk3.io, io_sh[7:1]};
            nbits3++;
            if (nbits3 % 8 == 0) io_q.push_back(io_sh);
        end
    end
    // ==========================================
    // Tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic push(input logic [7:0] d, input logic l);
        @(negedge clk);
        cmd_valid = 1'h1;
        cmd_data  = d;
        cmd_last  = l;
        while (cmd_ready !== 1'h1 || cmd_ready3 !== 1'h1) @(negedge clk);
        @(posedge clk);
        @(negedge clk);
        cmd_valid = 1'h0;
    endtask
    // One transaction: address, then n data bytes (dummies for reads)
    task automatic xfer(input logic [7:0] a, input logic [31:0] d, input int n);
        int k;
        int s0;
        int s3;
        int r0;
        wa_q.delete(); wd_q.delete(); rd_q.delete(); mo_q.delete(); so_q.delete();
        io_q.delete();
        rd3_q.delete();
        nbits = 0;
        nbits3 = 0;
        s0 = snap_cnt;
        s3 = snap3_cnt;
        r0 = re_cnt;
        push(a, n == 0);
        for (int i = 0; i < n; i++) push(d[8*i +: 8], i == n - 1);
        k = 0;
        // A hang here is caught by the cycle watchdog
        while (k < 4 || h_busy !== 1'h0 || h_busy3 !== 1'h0) begin
            @(negedge clk);
            k++;
        end
        repeat (16) @(negedge clk);
        check("bit count", nbits, 8 * (n + 1));
        check("snapshots", snap_cnt - s0, 1);
        check("address on wire", mo_q[0], a);
        check("output during address", so_q[0], 8'hFF);
        check("read strobes", re_cnt - r0, a[7] ? 0 : n);
        check("device idle", d_busy, 1'h0);
        check("3-wire bit count", nbits3, 8 * (n + 1));
        check("3-wire snapshots", snap3_cnt - s3, 1);
        check("3-wire address", io_q[0], a);
        check("3-wire reads", rd3_q.size(), a[7] ? 0 : n);
    endtask
    task automatic report_and_stop();
        $display("n_errors=%0d tests_run=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // Clock, reset and tests
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    initial begin
        logic [23:0] e;
        nrst = 1'h0; cmd_valid = 1'h0; cmd_data = 8'h00; cmd_last = 1'h0;
        mo_sh = 8'h00; so_sh = 8'h00; nbits = 0; snap_cnt = 0; cycles = 0; n_errors = 0; tests_run = 0;
        for (int i = 0; i < 16; i++) begin
            mem[i] = 8'hA0 + 8'(i);
            mem3[i] = 8'hA0 + 8'(i);
        end
        repeat (4) @(posedge clk);
        @(negedge clk);
        nrst = 1'h1;
        // Write burst across the top of the writable block
        xfer(8'h8E, 32'h00332211, 3);
        for (int i = 0; i < 3; i++) begin
            check("write address", wa_q[i], {4'h8, 4'(14 + i)});
            check("write data", wd_q[i], 8'h11 * (i + 1));
            check("data on wire", mo_q[i + 1], 8'h11 * (i + 1));
            check("3-wire data on wire", io_q[i + 1], 8'h11 * (i + 1));
        end
        check("reads in write", rd_q.size(), 0);
        // Read burst across the wrap point
        e = 24'hA13322;
        xfer(8'h0F, 32'h00000000, 3);
        for (int i = 0; i < 3; i++) begin
            check("read data", rd_q[i], e[8*i +: 8]);
            check("read on wire", so_q[i + 1], e[8*i +: 8]);
            check("3-wire read", rd3_q[i], e[8*i +: 8]);
            check("3-wire read on wire", io_q[i + 1], e[8*i +: 8]);
        end
        check("writes in read", wa_q.size(), 0);
        // Single-byte read
        xfer(8'h05, 32'h00000000, 1);
        check("single read", rd_q[0], 8'hA5);
        check("single count", rd_q.size(), 1);
        check("3-wire single read", rd3_q[0], 8'hA5);
        report_and_stop();
    end
endmodule
`default_nettype wire
